//--- core/stu_top.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module stu_top import stu_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRData,
  input  wire logic        smpInValid,
  output logic             smpInReady,
  input  wire stu_smp_t    smpIn,
  output logic             smpOutValid,
  input  wire logic        smpOutReady,
  output stu_res_t         smpOut
);
  logic [4:0]    ctrl;
  logic [11:0]   frontOps;
  logic [11:0]   backOps;
  logic [31:0]   cfgMasks;
  logic [SW-1:0] cfgRef;
  logic [SW-1:0] dynCmpF;
  logic [SW-1:0] dynCmpB;
  logic [SW-1:0] dynUpdF;
  logic [SW-1:0] dynUpdB;
  logic [SW-1:0] dynRefF;
  logic [SW-1:0] dynRefB;
  logic [15:0]   passCnt;
  logic [15:0]   failCnt;
  logic [15:0]   next_passCnt;
  logic [15:0]   next_failCnt;
  stu_face_t     frontSt;
  stu_face_t     backSt;
  stu_face_t     selSt;
  stu_res_t      evalRes;
  logic          stencilOk;
  logic          active;
  logic          push;
  logic          wrCtrl;
  logic          wrCmp;
  logic          wrUpd;
  logic          wrRef;
  logic          wrStat;
  logic [1:0]    face;
  logic [2:0]    selAct;
  logic [SW-1:0] chkRef;
  logic [SW-1:0] chkTest;

  // write decode
  assign face   = regWData[FACE_LSB+1:FACE_LSB];
  assign wrCtrl = regWr && regAddr == CTRL_OFS;
  assign wrCmp  = regWr && regAddr == CMD_CMP_OFS;
  assign wrUpd  = regWr && regAddr == CMD_UPD_OFS;
  assign wrRef  = regWr && regAddr == CMD_REF_OFS;
  assign wrStat = regWr && regAddr == STATUS_OFS;

  // pipeline configuration registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl     <= CTRL_RST;
      frontOps <= OPS_RST;
      backOps  <= OPS_RST;
      cfgMasks <= MASKS_RST;
      cfgRef   <= REF_RST;
    end else if (regWr) begin
      if (wrCtrl) begin
        ctrl <= regWData[4:0];
      end else if (regAddr == FRONT_OFS) begin
        frontOps <= regWData[11:0];
      end else if (regAddr == BACK_OFS) begin
        backOps <= regWData[11:0];
      end else if (regAddr == MASKS_OFS) begin
        cfgMasks <= regWData;
      end else if (regAddr == REF_OFS) begin
        cfgRef <= regWData[SW-1:0];
      end
    end
  end

  // dynamic loads: bit 0 of face hits front, bit 1 back
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dynCmpF <= VAL_RST;
      dynCmpB <= VAL_RST;
      dynUpdF <= VAL_RST;
      dynUpdB <= VAL_RST;
      dynRefF <= REF_RST;
      dynRefB <= REF_RST;
    end else begin
      if (wrCmp && face[0]) dynCmpF <= regWData[SW-1:0];
      if (wrCmp && face[1]) dynCmpB <= regWData[SW-1:0];
      if (wrUpd && face[0]) dynUpdF <= regWData[SW-1:0];
      if (wrUpd && face[1]) dynUpdB <= regWData[SW-1:0];
      if (wrRef && face[0]) dynRefF <= regWData[SW-1:0];
      if (wrRef && face[1]) dynRefB <= regWData[SW-1:0];
    end
  end

  // a face select of zero loads nothing, harmless

  // per-face effective state, dynamic or configured
  always_comb begin
    frontSt.failAct           = frontOps[FAIL_LSB+2:FAIL_LSB];
    frontSt.passAct           = frontOps[PASS_LSB+2:PASS_LSB];
    frontSt.depthMissAction   = frontOps[MISS_LSB+2:MISS_LSB];
    frontSt.comparisonKindSel = frontOps[KIND_LSB+2:KIND_LSB];
    frontSt.compareBitMask    = ctrl[DYNCMP_BIT] ? dynCmpF : cfgMasks[7:0];
    frontSt.updateBitMask     = ctrl[DYNUPD_BIT] ? dynUpdF : cfgMasks[23:16];
    frontSt.refValue          = ctrl[DYNREF_BIT] ? dynRefF : cfgRef;
    backSt.failAct            = backOps[FAIL_LSB+2:FAIL_LSB];
    backSt.passAct            = backOps[PASS_LSB+2:PASS_LSB];
    backSt.depthMissAction    = backOps[MISS_LSB+2:MISS_LSB];
    backSt.comparisonKindSel  = backOps[KIND_LSB+2:KIND_LSB];
    backSt.compareBitMask     = ctrl[DYNCMP_BIT] ? dynCmpB : cfgMasks[15:8];
    backSt.updateBitMask      = ctrl[DYNUPD_BIT] ? dynUpdB : cfgMasks[31:24];
    backSt.refValue           = ctrl[DYNREF_BIT] ? dynRefB : cfgRef;
  end

  // facing picks the set; other primitives arrive as front
  assign selSt  = smpIn.backFace ? backSt : frontSt;
  assign active = ctrl[CHECK_BIT] && ctrl[ATTACH_BIT];
  assign push   = smpInValid && smpInReady;

  stu_eval u_eval (
    .active    (active),
    .smp       (smpIn),
    .st        (selSt),
    .stencilOk (stencilOk),
    .res       (evalRes)
  );

  // two-entry buffer: receiver stall backs up to the source
  stu_skid2 #(.W($bits(stu_res_t))) u_buf (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (smpInValid),
    .inReady  (smpInReady),
    .inData   (evalRes),
    .outValid (smpOutValid),
    .outReady (smpOutReady),
    .outData  (smpOut)
  );

  // sample counters; a clear and a count in the same cycle leave the counter at one
  always_comb begin
    next_passCnt = wrStat ? 16'h0000 : passCnt;
    next_failCnt = wrStat ? 16'h0000 : failCnt;
    if (push && active && smpIn.covered) begin
      if (stencilOk) next_passCnt = next_passCnt + 16'h0001;
      else next_failCnt = next_failCnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      passCnt <= 16'h0000;
      failCnt <= 16'h0000;
    end else begin
      passCnt <= next_passCnt;
      failCnt <= next_failCnt;
    end
  end

  // read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRData <= 32'h00000000;
    end else if (!regRd) begin
      regRData <= 32'h00000000;
    end else if (regAddr == CTRL_OFS) begin
      regRData <= {27'h0000000, ctrl};
    end else if (regAddr == FRONT_OFS) begin
      regRData <= {20'h00000, frontOps};
    end else if (regAddr == BACK_OFS) begin
      regRData <= {20'h00000, backOps};
    end else if (regAddr == MASKS_OFS) begin
      regRData <= cfgMasks;
    end else if (regAddr == REF_OFS) begin
      regRData <= {24'h000000, cfgRef};
    end else if (regAddr == CMD_CMP_OFS) begin
      regRData <= {16'h0000, dynCmpB, dynCmpF};
    end else if (regAddr == CMD_UPD_OFS) begin
      regRData <= {16'h0000, dynUpdB, dynUpdF};
    end else if (regAddr == CMD_REF_OFS) begin
      regRData <= {16'h0000, dynRefB, dynRefF};
    end else if (regAddr == STATUS_OFS) begin
      regRData <= {failCnt, passCnt};
    end else begin
      regRData <= 32'h00000000;
    end
  end

  // check-side masked operands and chosen action, kept apart from the evaluator
  assign chkRef  = selSt.refValue & selSt.compareBitMask;
  assign chkTest = smpIn.stored & selSt.compareBitMask;

  always_comb begin
    selAct = selSt.depthMissAction;
    if (!stencilOk) begin
      selAct = selSt.failAct;
    end else if (smpIn.depthPass) begin
      selAct = selSt.passAct;
    end
  end

  // checks
  sequence pushIdle;
    push && !smpOutValid;
  endsequence

  sequence lands;
    smpOutValid && smpOut == $past(evalRes);
  endsequence

  // a covered sample accepted while the test is on
  sequence tested;
    push && active && smpIn.covered;
  endsequence

  // a result waiting at the output for the store
  sequence heldOut;
    smpOutValid && !smpOutReady;
  endsequence

  bypass_pass_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && !active |-> evalRes.covered == smpIn.covered && !evalRes.writeEn)
    else $error("coverage altered while check off");

  back_select_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && smpIn.backFace |-> selSt.comparisonKindSel == backOps[KIND_LSB+2:KIND_LSB])
    else $error("back sample used front set");

  fail_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && active && !stencilOk |-> !evalRes.covered)
    else $error("failed sample kept coverage");

  merge_mask_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && evalRes.writeEn |-> ((evalRes.newStencil ^ smpIn.stored) & ~selSt.updateBitMask) == '0)
    else $error("unmasked stencil bit changed");

  cmp_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrCmp && face == FRONT_FACE_FLAG |=> dynCmpF == $past(regWData[SW-1:0]) && $stable(dynCmpB))
    else $error("front compare mask load wrong");

  upd_back_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrUpd && face == BACK_FACE_FLAG |=> $stable(dynUpdF) && dynUpdB == $past(regWData[SW-1:0]))
    else $error("back update mask load wrong");

  ref_both_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrRef && face == BOTH_FACES_FLAG |=> dynRefF == $past(regWData[SW-1:0])
      && dynRefB == dynRefF)
    else $error("both-face reference load wrong");

  fixed_latency_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    pushIdle |=> lands)
    else $error("sample not out one cycle after accept");

  never_fails_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selSt.comparisonKindSel == CMP_NEVER) |-> !evalRes.covered)
    else $error("never comparison kept coverage");

  always_passes_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selSt.comparisonKindSel == CMP_ALWAYS) |-> evalRes.covered)
    else $error("always comparison dropped coverage");

  masked_equal_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selSt.comparisonKindSel == CMP_EQ) |-> stencilOk == (chkRef == chkTest))
    else $error("equal test ignored compare mask");

  unsigned_less_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selSt.comparisonKindSel == CMP_LT) |-> stencilOk == (chkRef < chkTest))
    else $error("less test wrong");

  greater_equal_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selSt.comparisonKindSel == CMP_GE) |-> stencilOk == (chkRef >= chkTest))
    else $error("greater-or-equal test wrong");

  front_select_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && !smpIn.backFace |-> selSt == frontSt)
    else $error("front sample used back set");

  back_update_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && smpIn.backFace |-> selSt.updateBitMask == backSt.updateBitMask)
    else $error("back sample used front update mask");

  keep_action_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_KEEP) |-> evalRes.newStencil == smpIn.stored)
    else $error("keep action changed stencil");

  zero_action_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_ZERO) |-> (evalRes.newStencil & selSt.updateBitMask) == '0)
    else $error("zero action left bits set");

  repl_action_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_REPL)
      |-> ((evalRes.newStencil ^ selSt.refValue) & selSt.updateBitMask) == '0)
    else $error("replace action wrong");

  inc_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_INCW)
      |-> ((evalRes.newStencil ^ (smpIn.stored + 8'h01)) & selSt.updateBitMask) == '0)
    else $error("wrapping increment wrong");

  dec_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_DECW)
      |-> ((evalRes.newStencil ^ (smpIn.stored - 8'h01)) & selSt.updateBitMask) == '0)
    else $error("wrapping decrement wrong");

  inc_clamp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_INCC && (&smpIn.stored)) |-> evalRes.newStencil == smpIn.stored)
    else $error("clamped increment passed maximum");

  dec_clamp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_DECC && smpIn.stored == '0) |-> evalRes.newStencil == '0)
    else $error("clamped decrement went below zero");

  invert_merge_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (selAct == ACT_INV)
      |-> ((evalRes.newStencil ^ ~smpIn.stored) & selSt.updateBitMask) == '0)
    else $error("masked bits not updated");

  uncovered_kept_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && !smpIn.covered |-> !evalRes.writeEn && evalRes.newStencil == smpIn.stored)
    else $error("uncovered sample written");

  write_enable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested |-> evalRes.writeEn)
    else $error("tested sample not written back");

  fail_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (!stencilOk && !wrStat) |=> failCnt == $past(failCnt) + 16'h0001)
    else $error("failed sample not counted");

  pass_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tested ##0 (stencilOk && !wrStat) |=> passCnt == $past(passCnt) + 16'h0001)
    else $error("passed sample not counted");

  hold_output_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    heldOut |=> smpOutValid && $stable(smpOut))
    else $error("stalled result lost");

  full_stall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !smpInReady |-> smpOutValid)
    else $error("source stalled with empty buffer");

  ctrl_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wrCtrl |=> ctrl == $past(regWData[4:0]))
    else $error("control write lost");

  dyn_compare_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && ctrl[DYNCMP_BIT] && !smpIn.backFace |-> selSt.compareBitMask == dynCmpF)
    else $error("dynamic compare mask not used");

  cfg_update_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    push && !ctrl[DYNUPD_BIT] && smpIn.backFace |-> selSt.updateBitMask == cfgMasks[31:24])
    else $error("configured back update mask not used");

endmodule
`default_nettype wire

//--- core/stu_pkg.sv
// Contract
// - check off or no attachment: coverage passes
// - back-facing uses back set, else front
// - comparison kind taken from selected face
// - reference and stored both ANDed with compare mask
// - masked values compared as unsigned integers
// - failed comparison clears sample coverage
// - fail, pass or depth-miss action chosen
// - merge new value under update mask
// - face select: 1 front, 2 back, 3 both
// - dynamic compare mask loads selected faces
// - dynamic update mask loads selected faces
// - actions 0..7: keep to decrement wrap
// - increment clamps at max, unsigned arithmetic
// - dynamic reference loads selected faces
package stu_pkg;
  localparam int SW = 8;
  // register offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] FRONT_OFS    = 8'h04;
  localparam logic [7:0] BACK_OFS     = 8'h08;
  localparam logic [7:0] MASKS_OFS    = 8'h0c;
  localparam logic [7:0] REF_OFS      = 8'h10;
  localparam logic [7:0] CMD_CMP_OFS  = 8'h14;
  localparam logic [7:0] CMD_UPD_OFS  = 8'h18;
  localparam logic [7:0] CMD_REF_OFS  = 8'h1c;
  localparam logic [7:0] STATUS_OFS   = 8'h20;
  // field positions
  localparam int CHECK_BIT  = 0;
  localparam int ATTACH_BIT = 1;
  localparam int DYNCMP_BIT = 2;
  localparam int DYNUPD_BIT = 3;
  localparam int DYNREF_BIT = 4;
  localparam int FAIL_LSB   = 0;
  localparam int PASS_LSB   = 3;
  localparam int MISS_LSB   = 6;
  localparam int KIND_LSB   = 9;
  localparam int FACE_LSB   = 8;
  // reset values
  localparam logic [4:0]  CTRL_RST  = 5'h00;
  localparam logic [11:0] OPS_RST   = 12'h000;
  localparam logic [31:0] MASKS_RST = 32'hffffffff;
  localparam logic [7:0]  VAL_RST   = 8'hff;
  localparam logic [7:0]  REF_RST   = 8'h00;
  // face select encodings
  localparam logic [1:0] FRONT_FACE_FLAG = 2'h1;
  localparam logic [1:0] BACK_FACE_FLAG  = 2'h2;
  localparam logic [1:0] BOTH_FACES_FLAG = 2'h3;
  // stencil_update_action codes
  localparam logic [2:0] ACT_KEEP = 3'h0;
  localparam logic [2:0] ACT_ZERO = 3'h1;
  localparam logic [2:0] ACT_REPL = 3'h2;
  localparam logic [2:0] ACT_INCC = 3'h3;
  localparam logic [2:0] ACT_DECC = 3'h4;
  localparam logic [2:0] ACT_INV  = 3'h5;
  localparam logic [2:0] ACT_INCW = 3'h6;
  localparam logic [2:0] ACT_DECW = 3'h7;
  // comparison_kind codes
  localparam logic [2:0] CMP_NEVER = 3'h0;
  localparam logic [2:0] CMP_LT    = 3'h1;
  localparam logic [2:0] CMP_EQ    = 3'h2;
  localparam logic [2:0] CMP_LE    = 3'h3;
  localparam logic [2:0] CMP_GT    = 3'h4;
  localparam logic [2:0] CMP_NE    = 3'h5;
  localparam logic [2:0] CMP_GE    = 3'h6;
  localparam logic [2:0] CMP_ALWAYS = 3'h7;
  typedef struct packed {
    logic [2:0]    failAct;
    logic [2:0]    passAct;
    logic [2:0]    depthMissAction;
    logic [2:0]    comparisonKindSel;
    logic [SW-1:0] compareBitMask;
    logic [SW-1:0] updateBitMask;
    logic [SW-1:0] refValue;
  } stu_face_t;
  typedef struct packed {
    logic          covered;
    logic          backFace;
    logic          depthPass;
    logic [SW-1:0] stored;
  } stu_smp_t;
  typedef struct packed {
    logic          covered;
    logic          writeEn;
    logic [SW-1:0] newStencil;
  } stu_res_t;
endpackage

//--- core/stu_skid2.sv
`timescale 1ns/1ns
`default_nettype none
module stu_skid2 import stu_pkg::*; #(
  parameter int W = 10
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  logic         v1;
  logic [W-1:0] slot1;
  logic         push;
  logic         pop;
  // head always in slot 0 so the output is a plain flop
  assign push = inValid && inReady;
  assign pop  = outValid && outReady;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid <= 1'b0;
      v1       <= 1'b0;
      inReady  <= 1'b1;
      outData  <= '0;
      slot1    <= '0;
    end else if (pop) begin
      if (v1) begin
        outData <= slot1;
        v1      <= 1'b0;
        inReady <= 1'b1;
      end else begin
        outValid <= push;
        if (push) outData <= inData;
      end
    end else if (push) begin
      if (!outValid) begin
        outData  <= inData;
        outValid <= 1'b1;
      end else begin
        slot1   <= inData;
        v1      <= 1'b1;
        inReady <= 1'b0; // full: stall the source
      end
    end
  end
endmodule
`default_nettype wire

//--- core/stu_eval.sv
`timescale 1ns/1ns
`default_nettype none
module stu_eval import stu_pkg::*; (
  input  wire logic      active,
  input  wire stu_smp_t  smp,
  input  wire stu_face_t st,
  output logic           stencilOk,
  output stu_res_t       res
);
  logic [SW-1:0] mRef;
  logic [SW-1:0] mTest;
  logic [2:0]    act;
  logic [SW-1:0] gen;
  // masked operands, reference on the left
  assign mRef  = st.refValue & st.compareBitMask;
  assign mTest = smp.stored & st.compareBitMask;
  always_comb begin
    case (st.comparisonKindSel)
      CMP_NEVER: stencilOk = 1'b0;
      CMP_LT:    stencilOk = mRef < mTest;
      CMP_EQ:    stencilOk = mRef == mTest;
      CMP_LE:    stencilOk = mRef <= mTest;
      CMP_GT:    stencilOk = mRef > mTest;
      CMP_NE:    stencilOk = mRef != mTest;
      CMP_GE:    stencilOk = mRef >= mTest;
      default:   stencilOk = 1'b1;
    endcase
  end
  // action select and new value
  always_comb begin
    if (!stencilOk) act = st.failAct;
    else if (smp.depthPass) act = st.passAct;
    else act = st.depthMissAction;
    case (act)
      ACT_KEEP: gen = smp.stored;
      ACT_ZERO: gen = '0;
      ACT_REPL: gen = st.refValue;
      ACT_INCC: gen = (&smp.stored) ? smp.stored : smp.stored + 1'b1;
      ACT_DECC: gen = (|smp.stored) ? smp.stored - 1'b1 : smp.stored;
      ACT_INV:  gen = ~smp.stored;
      ACT_INCW: gen = smp.stored + 1'b1;
      default:  gen = smp.stored - 1'b1;
    endcase
  end
  // off means untouched coverage and no write
  always_comb begin
    res.covered    = smp.covered;
    res.writeEn    = 1'b0;
    res.newStencil = smp.stored;
    if (active && smp.covered) begin
      res.covered    = stencilOk;
      res.writeEn    = 1'b1;
      res.newStencil = (smp.stored & ~st.updateBitMask)
                     | (gen & st.updateBitMask);
    end
  end
endmodule
`default_nettype wire

//--- verif/stu_sink.sv
`timescale 1ns/1ns
`default_nettype none
module stu_sink import stu_pkg::*; (
  input  wire logic     core_clk,
  input  wire logic     sys_rst,
  input  wire logic     stall,
  input  wire logic     smpOutValid,
  output logic          smpOutReady,
  input  wire stu_res_t smpOut
);
  stu_res_t got [$];
  // attachment store; stall models a busy memory port
  assign smpOutReady = !stall;
  // keep each accepted result in arrival order; reset drops what was kept
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      got.delete();
    end else if (smpOutValid && smpOutReady) begin
      got.push_back(smpOut);
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_stencil_test_unit.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nErrors++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_stencil_test_unit import stu_pkg::*;;
  typedef struct packed {
    logic [11:0] ops;
    logic [7:0]  refv;
    stu_smp_t    smp;
    stu_res_t    res;
  } stu_row_t;
  logic        coreClk, sysRst, regWr, regRd, smpInValid, smpInReady;
  logic        smpOutValid, smpOutReady, stall;
  logic [7:0]  regAddr;
  logic [31:0] regWData, regRData;
  stu_smp_t    smpIn;
  stu_res_t    smpOut;
  stu_row_t    rows [18];
  int          nErrors = 0;
  int          checked = 0;

  stu_top i_dut (.core_clk(coreClk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWData(regWData), .regWr(regWr), .regRd(regRd), .regRData(regRData),
    .smpInValid(smpInValid), .smpInReady(smpInReady), .smpIn(smpIn),
    .smpOutValid(smpOutValid), .smpOutReady(smpOutReady), .smpOut(smpOut));
  stu_sink i_sink (.core_clk(coreClk), .sys_rst(sysRst), .stall(stall),
    .smpOutValid(smpOutValid), .smpOutReady(smpOutReady), .smpOut(smpOut));

  // free-running pipeline clock, 4 ns period
  initial begin
    coreClk = 1'b0;
    forever #2 coreClk = ~coreClk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // single-cycle register write, entered and left at a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge coreClk);
    regAddr <= a;
    regWData <= d;
    regWr <= 1'b1;
    @(posedge coreClk);
    regWr <= 1'b0;
  endtask

  // read data only stands in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge coreClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge coreClk);
    regRd <= 1'b0;
    @(negedge coreClk);
    `CHK(regRData, e)
    @(posedge coreClk);
  endtask

  // holds valid until a rising edge sees ready; valid stays up for chaining
  task automatic put(input stu_smp_t s);
    int n;
    n = 0;
    smpInValid <= 1'b1;
    smpIn <= s;
    @(negedge coreClk);
    while (smpInReady !== 1'b1 && n < 100) begin
      @(negedge coreClk);
      n++;
    end
    `CHK(smpInReady, 1'b1)
    @(posedge coreClk);
  endtask

  task automatic take(input stu_res_t e);
    int n;
    stu_res_t r;
    n = 0;
    r = '0;
    while (i_sink.got.size() == 0 && n < 50) begin
      @(negedge coreClk);
      n++;
    end
    `CHK(i_sink.got.size() != 0, 1'b1)
    if (i_sink.got.size() != 0) r = i_sink.got.pop_front();
    `CHK(r, e)
  endtask

  task automatic one(input stu_smp_t s, input stu_res_t e);
    put(s);
    smpInValid <= 1'b0;
    take(e);
    @(posedge coreClk);
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge coreClk);
    nErrors++;
    results();
  end

  initial begin
    // ops {kind, miss, pass, fail}, reference, sample, expected result
    rows = '{'{12'h159, 8'h05, 11'h505, 10'h100}, '{12'h359, 8'h04, 11'h505, 10'h306},
      '{12'h359, 8'h05, 11'h505, 10'h100}, '{12'h559, 8'h05, 11'h505, 10'h306},
      '{12'h759, 8'h05, 11'h505, 10'h306}, '{12'h959, 8'h80, 11'h57f, 10'h380},
      '{12'hb59, 8'h05, 11'h505, 10'h100}, '{12'hd59, 8'h04, 11'h505, 10'h100},
      '{12'hf59, 8'h00, 11'h5ff, 10'h3ff}, '{12'hf41, 8'h3c, 11'h512, 10'h312},
      '{12'hf49, 8'h3c, 11'h512, 10'h300}, '{12'hf51, 8'h3c, 11'h512, 10'h33c},
      '{12'hf61, 8'h3c, 11'h500, 10'h300}, '{12'hf69, 8'h3c, 11'h512, 10'h3ed},
      '{12'hf71, 8'h3c, 11'h5ff, 10'h300}, '{12'hf79, 8'h3c, 11'h500, 10'h3ff},
      '{12'hf59, 8'h3c, 11'h40f, 10'h3f0}, '{12'hf59, 8'h3c, 11'h005, 10'h005}};
    sysRst = 1'b1;
    regAddr = 8'h00;
    regWData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    smpInValid = 1'b0;
    smpIn = '0;
    stall = 1'b0;
    repeat (6) @(posedge coreClk);
    `CHK({smpInReady, smpOutValid}, 2'h2)
    sysRst <= 1'b0;
    rd(CTRL_OFS, 32'h0);
    rd(MASKS_OFS, 32'hffffffff);
    rd(FRONT_OFS, 32'h0);
    rd(REF_OFS, 32'h0);
    rd(CMD_CMP_OFS, 32'h0000ffff);
    rd(8'h24, 32'h0);
    $display("reset test done");
    wr(CTRL_OFS, 32'h3);
    wr(STATUS_OFS, 32'h0);
    for (int i = 0; i < 18; i++) begin
      wr(FRONT_OFS, {20'h0, rows[i].ops});
      wr(REF_OFS, {24'h0, rows[i].refv});
      one(rows[i].smp, rows[i].res);
    end
    rd(STATUS_OFS, 32'h0004000d);
    $display("table test done");
    // two results fill the buffer while the store stalls
    wr(FRONT_OFS, 32'hf59);
    stall <= 1'b1;
    put(11'h501);
    put(11'h502);
    smpIn <= 11'h503;
    repeat (4) @(negedge coreClk);
    `CHK(smpInReady, 1'b0)
    `CHK({smpOutValid, smpOut}, 11'h702)
    @(posedge coreClk);
    stall <= 1'b0;
    put(11'h503);
    put(11'h504);
    smpInValid <= 1'b0;
    for (int i = 2; i < 6; i++) take(10'(10'h300 | i));
    $display("stall test done");
    wr(FRONT_OFS, 32'h159);
    wr(CTRL_OFS, 32'h2);
    one(11'h505, 10'h205);
    wr(CTRL_OFS, 32'h1);
    one(11'h505, 10'h205);
    wr(CTRL_OFS, 32'h3);
    wr(BACK_OFS, 32'hf59);
    one(11'h705, 10'h306);
    one(11'h505, 10'h100);
    wr(MASKS_OFS, 32'hfff0ff0f);
    wr(FRONT_OFS, 32'h429);
    wr(REF_OFS, 32'ha5);
    one(11'h535, 10'h3c5);
    $display("face and mask test done");
    // face select is never zero on these loads
    wr(MASKS_OFS, 32'hffffffff);
    wr(CTRL_OFS, 32'h1f);
    wr(CMD_CMP_OFS, 32'h10f);
    wr(CMD_UPD_OFS, 32'h20f);
    wr(CMD_REF_OFS, 32'h333);
    rd(CMD_CMP_OFS, 32'hff0f);
    rd(CMD_UPD_OFS, 32'h0fff);
    rd(CMD_REF_OFS, 32'h3333);
    wr(FRONT_OFS, 32'h411);
    wr(BACK_OFS, 32'h411);
    one(11'h553, 10'h333);
    one(11'h753, 10'h150);
    $display("dynamic test done");
    @(posedge coreClk);
    sysRst <= 1'b1;
    @(negedge coreClk);
    `CHK({smpInReady, smpOutValid}, 2'h2)
    repeat (5) @(posedge coreClk);
    sysRst <= 1'b0;
    rd(CTRL_OFS, 32'h0);
    rd(CMD_REF_OFS, 32'h0);
    one(11'h505, 10'h205);
    $display("second reset test done");
    results();
  end
endmodule
`default_nettype wire
